// [common/imdu_pkg.sv]
/*
  Package for the iterative multiply/divide unit: register addresses, control field positions, reset values and
  operation lengths.
  Assumes an internal byte-wide memory-mapped bus from the CPU core, with 16-bit addresses.
*/
package imdu_pkg;

  // ----------------------------------------
  // register addresses
  // ----------------------------------------
  localparam logic [15:0] ADDR_SDR_L  = 16'hFF60;
  localparam logic [15:0] ADDR_SDR_H  = 16'hFF61;
  localparam logic [15:0] ADDR_MDA_LL = 16'hFF62;
  localparam logic [15:0] ADDR_MDA_LH = 16'hFF63;
  localparam logic [15:0] ADDR_MDA_HL = 16'hFF64;
  localparam logic [15:0] ADDR_MDA_HH = 16'hFF65;
  localparam logic [15:0] ADDR_MDB_L  = 16'hFF66;
  localparam logic [15:0] ADDR_MDB_H  = 16'hFF67;
  localparam logic [15:0] ADDR_CTRL   = 16'hFF68;

  // ----------------------------------------
  // control fields and reset values
  // ----------------------------------------
  localparam int          CTRL_RUN_BIT  = 7;
  localparam int          CTRL_MODE_BIT = 0;
  localparam logic [7:0]  CTRL_RESET    = 8'h00;
  localparam logic [15:0] HALF_RESET    = 16'h0000;

  // ----------------------------------------
  // operation lengths in internal clocks
  // ----------------------------------------
  localparam logic [5:0] MUL_CYCLES = 6'h10;
  localparam logic [5:0] DIV_CYCLES = 6'h20;

  typedef enum logic [1:0] {
    IMDU_IDLE = 2'b00,
    IMDU_BUSY = 2'b01
  } imdu_state_t;

endpackage : imdu_pkg

// [common/imdu_step_if.sv]
/*
  Interface carrying one iteration step between the core and its arithmetic step module.
  Assumes the step module is purely combinational.
*/
interface imdu_step_if;
  logic        mode_mul;
  logic [31:0] acc_in;
  logic [15:0] rem_in;
  logic [15:0] opb;
  logic [31:0] acc_out;
  logic [15:0] rem_out;
  modport core (output mode_mul, output acc_in, output rem_in, output opb, input acc_out, input rem_out);
  modport step (input mode_mul, input acc_in, input rem_in, input opb, output acc_out, output rem_out);
endinterface : imdu_step_if

// [hdl/imdu_step.sv]
/*
  One unsigned iteration: shift-add multiply step or restoring divide step.
  Assumes the caller registers the results each clock.
*/
module imdu_step (
  imdu_step_if.step s
);
  logic [16:0] trial;
  logic [16:0] diff;
  logic [16:0] psum;

  // ----------------------------------------
  // datapath
  // ----------------------------------------
  // multiply: product high half in acc[31:16], multiplier shifts out of acc[15:0]
  // divide: partial remainder shifts in the dividend MSB, quotient bit enters acc LSB
  always_comb begin
    psum  = {1'b0, s.acc_in[31:16]} + (s.acc_in[0] ? {1'b0, s.opb} : 17'h00000);
    trial = {s.rem_in, s.acc_in[31]};
    diff  = trial - {1'b0, s.opb};
    if (s.mode_mul) begin
      s.acc_out = {psum, s.acc_in[15:1]};
      s.rem_out = s.rem_in;
    end else if (!diff[16]) begin
      s.acc_out = {s.acc_in[30:0], 1'b1};
      s.rem_out = diff[15:0];
    end else begin
      s.acc_out = {s.acc_in[30:0], 1'b0};
      s.rem_out = trial[15:0];
    end
  end
endmodule : imdu_step

// [hdl/imdu_bus_dec.sv]
/*
  Read multiplexer for the unit's byte registers.
  Assumes registered read data is taken by the caller.
*/
module imdu_bus_dec (
  input  wire logic [15:0] addr,
  input  wire logic [31:0] opa,
  input  wire logic [15:0] opb,
  input  wire logic [15:0] rem,
  input  wire logic [7:0]  ctrl,
  output logic      [7:0]  rdata
);
  // ----------------------------------------
  // read decode, unmapped reads return zero
  // ----------------------------------------
  always_comb begin
    unique case (addr)
      imdu_pkg::ADDR_SDR_L:  rdata = rem[7:0];
      imdu_pkg::ADDR_SDR_H:  rdata = rem[15:8];
      imdu_pkg::ADDR_MDA_LL: rdata = opa[7:0];
      imdu_pkg::ADDR_MDA_LH: rdata = opa[15:8];
      imdu_pkg::ADDR_MDA_HL: rdata = opa[23:16];
      imdu_pkg::ADDR_MDA_HH: rdata = opa[31:24];
      imdu_pkg::ADDR_MDB_L:  rdata = opb[7:0];
      imdu_pkg::ADDR_MDB_H:  rdata = opb[15:8];
      imdu_pkg::ADDR_CTRL:   rdata = ctrl;
      default:               rdata = 8'h00;
    endcase
  end
endmodule : imdu_bus_dec

// [hdl/imdu_core.sv]
/*
  Iterative unsigned 16x16 multiplier and 32/16 divider on the core's internal byte bus.
  Assumes a single-cycle bus: wr_en with wr_mask selects bits for control bit writes, other registers take whole bytes; rd_en returns data next cycle.
*/
module imdu_core (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic [15:0] addr,
  input  wire logic        wr_en,
  input  wire logic [7:0]  wr_data,
  input  wire logic [7:0]  wr_mask,
  input  wire logic        rd_en,
  input  wire logic        serial_done_irq,
  output logic      [7:0]  rd_data,
  output logic             muldiv_done_irq,
  output logic             shared_irq
);
  logic [31:0]          operand_a_q;
  logic [15:0]          operand_b_q;
  logic [15:0]          remainder_q;
  logic                 run_q;
  logic                 mode_q;
  logic [5:0]           count_q;
  logic                 done_q;
  logic                 shared_q;
  logic [7:0]           rd_data_q;
  imdu_pkg::imdu_state_t state_q;
  logic [7:0]           ctrl_view;
  logic [7:0]           ctrl_new;
  logic [7:0]           rmux;
  logic                 ctrl_wr;
  logic                 start;
  logic                 finish;
  logic                 stop;
  logic [5:0]           last_count;

  imdu_step_if st ();

  // ----------------------------------------
  // submodules
  // ----------------------------------------
  imdu_step u_step (
    .s (st.step)
  );

  imdu_bus_dec u_dec (
    .addr  (addr),
    .opa   (operand_a_q),
    .opb   (operand_b_q),
    .rem   (remainder_q),
    .ctrl  (ctrl_view),
    .rdata (rmux)
  );

  // ----------------------------------------
  // control decode
  // ----------------------------------------
  // unused bits are not stored, so they read back zero
  assign ctrl_view = {run_q, 6'h00, mode_q};
  assign ctrl_wr   = wr_en && (addr == imdu_pkg::ADDR_CTRL);
  // masked merge lets a bit write touch one bit only
  assign ctrl_new  = (ctrl_view & ~wr_mask) | (wr_data & wr_mask);
  assign last_count = mode_q ? imdu_pkg::MUL_CYCLES - 6'h01 : imdu_pkg::DIV_CYCLES - 6'h01;
  assign finish    = (state_q == imdu_pkg::IMDU_BUSY) && (count_q == last_count);
  // a start is a rising of run seen by a write while idle
  assign start     = ctrl_wr && ctrl_new[imdu_pkg::CTRL_RUN_BIT] && !run_q;
  // software stop loses to a finish in the same cycle
  assign stop      = ctrl_wr && !ctrl_new[imdu_pkg::CTRL_RUN_BIT] && run_q && !finish;

  assign st.mode_mul = mode_q;
  assign st.acc_in   = operand_a_q;
  assign st.rem_in   = remainder_q;
  assign st.opb      = operand_b_q;

  // ----------------------------------------
  // control register
  // ----------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      run_q  <= imdu_pkg::CTRL_RESET[imdu_pkg::CTRL_RUN_BIT];
      mode_q <= imdu_pkg::CTRL_RESET[imdu_pkg::CTRL_MODE_BIT];
    end else begin
      if (ctrl_wr) begin
        mode_q <= ctrl_new[imdu_pkg::CTRL_MODE_BIT];
      end
      if (finish) begin
        run_q <= 1'b0;
      end else if (ctrl_wr) begin
        run_q <= ctrl_new[imdu_pkg::CTRL_RUN_BIT];
      end
    end
  end

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      state_q <= imdu_pkg::IMDU_IDLE;
      count_q <= 6'h00;
    end else begin
      unique case (state_q)
        imdu_pkg::IMDU_IDLE: begin
          count_q <= 6'h00;
          if (start) begin
            state_q <= imdu_pkg::IMDU_BUSY;
          end
        end
        imdu_pkg::IMDU_BUSY: begin
          count_q <= count_q + 6'h01;
          if (finish || stop) begin
            state_q <= imdu_pkg::IMDU_IDLE;
          end
        end
        default: begin
          state_q <= imdu_pkg::IMDU_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // operand A: bus writes, high-half clear on multiply start, iteration
  // ----------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      operand_a_q <= {imdu_pkg::HALF_RESET, imdu_pkg::HALF_RESET};
    end else if (state_q == imdu_pkg::IMDU_BUSY) begin
      operand_a_q <= st.acc_out;
    end else begin
      if (wr_en && addr == imdu_pkg::ADDR_MDA_LL) operand_a_q[7:0]   <= wr_data;
      if (wr_en && addr == imdu_pkg::ADDR_MDA_LH) operand_a_q[15:8]  <= wr_data;
      if (wr_en && addr == imdu_pkg::ADDR_MDA_HL) operand_a_q[23:16] <= wr_data;
      if (wr_en && addr == imdu_pkg::ADDR_MDA_HH) operand_a_q[31:24] <= wr_data;
      if (start && ctrl_new[imdu_pkg::CTRL_MODE_BIT]) begin
        operand_a_q[31:16] <= imdu_pkg::HALF_RESET;
      end
    end
  end

  // ----------------------------------------
  // operand B and remainder
  // ----------------------------------------
  // remainder is read-only to software; written only by start and iteration
  always_ff @(posedge clock) begin
    if (rst) begin
      operand_b_q <= imdu_pkg::HALF_RESET;
      remainder_q <= imdu_pkg::HALF_RESET;
    end else begin
      if (wr_en && addr == imdu_pkg::ADDR_MDB_L) operand_b_q[7:0]  <= wr_data;
      if (wr_en && addr == imdu_pkg::ADDR_MDB_H) operand_b_q[15:8] <= wr_data;
      if (start) begin
        remainder_q <= imdu_pkg::HALF_RESET;
      end else if (state_q == imdu_pkg::IMDU_BUSY) begin
        remainder_q <= st.rem_out;
      end
    end
  end

  // ----------------------------------------
  // done request, shared source and read data
  // ----------------------------------------
  // done rises with the flop that clears run, so both show in the same cycle
  always_ff @(posedge clock) begin
    if (rst) begin
      done_q   <= 1'b0;
      shared_q <= 1'b0;
    end else begin
      done_q   <= finish;
      shared_q <= finish || serial_done_irq;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      rd_data_q <= 8'h00;
    end else if (rd_en) begin
      rd_data_q <= rmux;
    end
  end

  assign rd_data         = rd_data_q;
  assign muldiv_done_irq = done_q;
  assign shared_irq      = shared_q;

  // ----------------------------------------
  // checks: operation length
  // ----------------------------------------
  // a stop is legal at any time, so the length checks only expect a done
  // pulse when no stop was seen on the way; finish itself masks a late stop
  sequence mul_start_s;
    start && ctrl_new[imdu_pkg::CTRL_MODE_BIT];
  endsequence

  sequence div_start_s;
    start && !ctrl_new[imdu_pkg::CTRL_MODE_BIT];
  endsequence

  sequence no_stop8_s;
    (!stop) [*8];
  endsequence

  // done must not show one edge early, then must show on the next edge
  sequence done_next_s;
    !muldiv_done_irq ##1 muldiv_done_irq;
  endsequence

  mul_length_a: assert property (@(posedge clock) disable iff (rst)
    mul_start_s ##1 no_stop8_s ##1 (!stop) [*7] |-> ##1 done_next_s)
    else $error("multiply did not finish in 16 clocks");
  div_length_a: assert property (@(posedge clock) disable iff (rst)
    div_start_s ##1 no_stop8_s ##1 no_stop8_s ##1 no_stop8_s ##1 (!stop) [*7] |-> ##1 done_next_s)
    else $error("divide did not finish in 32 clocks");
  count_bound_a: assert property (@(posedge clock) disable iff (rst)
    state_q == imdu_pkg::IMDU_BUSY |-> count_q <= last_count)
    else $error("iteration counter ran past its end");

  // ----------------------------------------
  // checks: control register
  // ----------------------------------------
  reset_idle_a: assert property (@(posedge clock) disable iff (rst)
    $past(rst) |-> ctrl_view == imdu_pkg::CTRL_RESET && state_q == imdu_pkg::IMDU_IDLE)
    else $error("control not cleared by reset");
  ctrl_read_a: assert property (@(posedge clock) disable iff (rst)
    rd_en && addr == imdu_pkg::ADDR_CTRL |=> rd_data[6:1] == 6'h00)
    else $error("unused control bits read nonzero");
  run_start_a: assert property (@(posedge clock) disable iff (rst)
    start |=> run_q && state_q == imdu_pkg::IMDU_BUSY)
    else $error("start did not set run");
  mode_pick_a: assert property (@(posedge clock) disable iff (rst)
    start |=> mode_q == $past(ctrl_new[imdu_pkg::CTRL_MODE_BIT]))
    else $error("mode not taken at start");
  bit_write_a: assert property (@(posedge clock) disable iff (rst)
    ctrl_wr && !wr_mask[imdu_pkg::CTRL_RUN_BIT] && !finish |=> run_q == $past(run_q))
    else $error("masked write changed run");
  run_clear_a: assert property (@(posedge clock) disable iff (rst)
    finish |=> !run_q && state_q == imdu_pkg::IMDU_IDLE)
    else $error("run not cleared at completion");
  abort_idle_a: assert property (@(posedge clock) disable iff (rst)
    stop |=> state_q == imdu_pkg::IMDU_IDLE && !muldiv_done_irq)
    else $error("abort did not stop the unit");
  race_done_a: assert property (@(posedge clock) disable iff (rst)
    (finish && ctrl_wr) |=> muldiv_done_irq && !run_q)
    else $error("done lost on simultaneous clear");

  // ----------------------------------------
  // checks: datapath
  // ----------------------------------------
  start_clr_a: assert property (@(posedge clock) disable iff (rst)
    start |=> remainder_q == 16'h0000)
    else $error("remainder not cleared on start");
  mul_high_a: assert property (@(posedge clock) disable iff (rst)
    mul_start_s |=> operand_a_q[31:16] == 16'h0000)
    else $error("high half not cleared on multiply start");
  mul_rem_zero_a: assert property (@(posedge clock) disable iff (rst)
    finish && mode_q |=> remainder_q == imdu_pkg::HALF_RESET)
    else $error("remainder nonzero after multiply");
  opa_iter_a: assert property (@(posedge clock) disable iff (rst)
    state_q == imdu_pkg::IMDU_BUSY |=> operand_a_q == $past(st.acc_out))
    else $error("operand A missed an iteration");
  rem_iter_a: assert property (@(posedge clock) disable iff (rst)
    state_q == imdu_pkg::IMDU_BUSY |=> remainder_q == $past(st.rem_out))
    else $error("remainder missed an iteration");

  // ----------------------------------------
  // checks: requests
  // ----------------------------------------
  done_clears_a: assert property (@(posedge clock) disable iff (rst)
    muldiv_done_irq |-> !run_q && $past(run_q))
    else $error("done without run clearing");
  done_pulse_a: assert property (@(posedge clock) disable iff (rst)
    muldiv_done_irq |=> !muldiv_done_irq)
    else $error("done held longer than a cycle");
  done_cause_a: assert property (@(posedge clock) disable iff (rst)
    muldiv_done_irq |-> $past(finish))
    else $error("done without a finished operation");
  shared_src_a: assert property (@(posedge clock) disable iff (rst)
    muldiv_done_irq |-> shared_irq)
    else $error("done missing from shared request");
  serial_pass_a: assert property (@(posedge clock) disable iff (rst)
    serial_done_irq |=> shared_irq)
    else $error("serial done missing from shared request");

endmodule : imdu_core

// [sim/imdu_cpu_model.sv]
/*
  CPU core model: byte writes with bit mask and byte reads on the unit's bus.
  Assumes calls come one at a time from the bench; each call first waits for a falling clock edge.
*/
module imdu_cpu_model (
  input  wire logic        clock,
  output logic      [15:0] addr,
  output logic             wr_en,
  output logic      [7:0]  wr_data,
  output logic      [7:0]  wr_mask,
  output logic             rd_en,
  input  wire logic [7:0]  rd_data
);
  timeunit 1ns;
  timeprecision 1ps;

  // idle bus at start
  initial begin
    addr    = 16'h0000;
    wr_en   = 1'b0;
    wr_data = 8'h00;
    wr_mask = 8'h00;
    rd_en   = 1'b0;
  end

  // ----------------------------------------
  // accesses
  // ----------------------------------------
  // lines inverted after release so stale values never look valid;
  // each access opens on its own falling edge, so back-to-back calls
  // never drive one line twice in a single time step
  task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic [7:0] m);
    @(negedge clock);
    addr    = a;
    wr_data = d;
    wr_mask = m;
    wr_en   = 1'b1;
    @(negedge clock);
    wr_en   = 1'b0;
    addr    = ~a;
    wr_data = ~d;
    wr_mask = ~m;
  endtask : wr

  // registered read data is valid after the edge that took rd_en
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(negedge clock);
    addr  = a;
    rd_en = 1'b1;
    @(negedge clock);
    rd_en = 1'b0;
    addr  = ~a;
    d     = rd_data;
  endtask : rd
endmodule : imdu_cpu_model

// [sim/test_iterative_mul_div_unit.sv]
/*
  Self-checking bench for the multiply/divide unit driven through the CPU core model.
  Assumes inputs change at the falling clock edge.
*/
module test_iterative_mul_div_unit;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clock;
  logic        rst;
  logic        serial_done_irq;
  logic [15:0] addr;
  logic        wr_en;
  logic        rd_en;
  logic [7:0]  wr_data;
  logic [7:0]  wr_mask;
  logic [7:0]  rd_data;
  logic        muldiv_done_irq;
  logic        shared_irq;
  logic [31:0] v;
  int          failures;
  int          compares;

  imdu_core dut (.clock(clock), .rst(rst), .addr(addr), .wr_en(wr_en), .wr_data(wr_data), .wr_mask(wr_mask),
    .rd_en(rd_en), .serial_done_irq(serial_done_irq), .rd_data(rd_data), .muldiv_done_irq(muldiv_done_irq),
    .shared_irq(shared_irq));
  imdu_cpu_model cpu (.clock(clock), .addr(addr), .wr_en(wr_en), .wr_data(wr_data), .wr_mask(wr_mask),
    .rd_en(rd_en), .rd_data(rd_data));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  // little-endian multi-byte read
  task automatic rdn(input logic [15:0] a, input int n, output logic [31:0] r);
    logic [7:0] b;
    r = 32'h00000000;
    for (int i = 0; i < n; i++) begin
      cpu.rd(a + 16'(i), b);
      r[8*i +: 8] = b;
    end
  endtask : rdn

  task automatic wr16(input logic [15:0] a, input logic [15:0] d);
    cpu.wr(a, d[7:0], 8'hFF);
    cpu.wr(a + 16'h0001, d[15:8], 8'hFF);
  endtask : wr16

  // load, start, time the done pulse, check results
  task automatic run_op(input logic mode, input logic [31:0] a, input logic [15:0] b);
    logic [31:0] ea;
    logic [31:0] er;
    int          n;
    ea = mode ? {16'h0000, a[15:0]} * {16'h0000, b} : a / {16'h0000, b};
    er = mode ? 32'h00000000 : a % {16'h0000, b};
    wr16(imdu_pkg::ADDR_MDA_LL, a[15:0]);
    wr16(imdu_pkg::ADDR_MDA_HL, a[31:16]);
    wr16(imdu_pkg::ADDR_MDB_L, b);
    cpu.wr(imdu_pkg::ADDR_CTRL, {1'b1, 6'h00, mode}, 8'hFF);
    n = 0;
    while (muldiv_done_irq !== 1'b1 && n < 100) begin
      @(negedge clock);
      n++;
    end
    chk(32'(n), mode ? 32'(imdu_pkg::MUL_CYCLES) : 32'(imdu_pkg::DIV_CYCLES), "cycles");
    @(negedge clock);
    chk(32'(muldiv_done_irq), 32'h00000000, "pulse");
    rdn(imdu_pkg::ADDR_CTRL, 1, v);
    chk(v, {31'h00000000, mode}, "ctrl");
    rdn(imdu_pkg::ADDR_MDA_LL, 4, v);
    chk(v, ea, "opa");
    rdn(imdu_pkg::ADDR_SDR_L, 2, v);
    chk(v, er, "rem");
    $display("test done: op mode %0d", mode);
  endtask : run_op

  task automatic final_report;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : final_report

  // ----------------------------------------
  // clock, watchdog, tests
  // ----------------------------------------
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // whole run is a few hundred cycles
  initial begin
    #200us;
    failures++;
    $display("wrong value at %0t: watchdog", $time);
    final_report();
  end

  initial begin
    rst             = 1'b1;
    serial_done_irq = 1'b0;
    failures        = 0;
    compares        = 0;
    repeat (3) @(negedge clock);
    rst = 1'b0;
    rdn(imdu_pkg::ADDR_CTRL, 1, v);
    chk(v, 32'h00000000, "ctrl reset");
    rdn(imdu_pkg::ADDR_SDR_L, 2, v);
    chk(v, 32'h00000000, "rem reset");
    rdn(16'hFF70, 1, v);
    chk(v, 32'h00000000, "unmapped");
    cpu.wr(imdu_pkg::ADDR_CTRL, 8'h7E, 8'hFF);
    rdn(imdu_pkg::ADDR_CTRL, 1, v);
    chk(v, 32'h00000000, "unused bits");
    cpu.wr(imdu_pkg::ADDR_CTRL, 8'hFF, 8'h01);
    rdn(imdu_pkg::ADDR_CTRL, 1, v);
    chk(v, 32'h00000001, "bit write");
    $display("test done: control");
    run_op(1'b1, 32'h5A5A00DA, 16'h0093);
    run_op(1'b1, 32'hFFFFFFFF, 16'hFFFF);
    run_op(1'b0, 32'hDCBA2586, 16'h0018);
    run_op(1'b0, 32'hFFFFFFFF, 16'h0001);
    run_op(1'b0, 32'h00000005, 16'hFFFF);
    // abort by clearing only the run bit, then no done pulse may follow
    cpu.wr(imdu_pkg::ADDR_CTRL, 8'h80, 8'hFF);
    repeat (5) @(negedge clock);
    cpu.wr(imdu_pkg::ADDR_CTRL, 8'h00, 8'h80);
    v = 32'h00000000;
    repeat (40) begin
      @(negedge clock);
      v = v | {31'h00000000, muldiv_done_irq};
    end
    chk(v, 32'h00000000, "abort irq");
    rdn(imdu_pkg::ADDR_CTRL, 1, v);
    chk(v, 32'h00000000, "abort ctrl");
    run_op(1'b1, 32'h00000003, 16'h0007);
    // clear lands on the completing edge: result and pulse kept
    wr16(imdu_pkg::ADDR_MDA_LL, 16'h0003);
    cpu.wr(imdu_pkg::ADDR_CTRL, 8'h81, 8'hFF);
    // the write opens one falling edge later, so it is taken on the 16th edge
    repeat (14) @(negedge clock);
    cpu.wr(imdu_pkg::ADDR_CTRL, 8'h00, 8'h80);
    chk(32'(muldiv_done_irq), 32'h00000001, "late clear irq");
    rdn(imdu_pkg::ADDR_MDA_LL, 4, v);
    chk(v, 32'h00000015, "late clear result");
    $display("test done: abort");
    serial_done_irq = 1'b1;
    @(negedge clock);
    serial_done_irq = 1'b0;
    chk(32'(shared_irq), 32'h00000001, "shared");
    @(negedge clock);
    chk(32'(shared_irq), 32'h00000000, "shared end");
    $display("test done: shared");
    // reset in mid-division: unit must come back idle with cleared registers
    cpu.wr(imdu_pkg::ADDR_CTRL, 8'h80, 8'hFF);
    repeat (4) @(negedge clock);
    rst = 1'b1;
    repeat (2) @(negedge clock);
    rst = 1'b0;
    rdn(imdu_pkg::ADDR_CTRL, 1, v);
    chk(v, 32'h00000000, "reset ctrl");
    rdn(imdu_pkg::ADDR_MDA_LL, 4, v);
    chk(v, 32'h00000000, "reset opa");
    rdn(imdu_pkg::ADDR_SDR_L, 2, v);
    chk(v, 32'h00000000, "reset rem");
    chk(32'(muldiv_done_irq), 32'h00000000, "reset irq");
    $display("test done: reset");
    final_report();
  end
endmodule : test_iterative_mul_div_unit
